/* rtl/flr_regs.vh */
// Purpose: constants for the fault log recorder
// Assumes: 20 MHz system clock
// Notes:   block byte positions and fault source codes
`ifndef FLR_REGS_VH
`define FLR_REGS_VH
`define FLR_BLOCK_LEN      8'h93
`define FLR_SNAP_BASE      8'h1B
`define FLR_SNAP_BYTES     8'h14
`define FLR_LAST_BYTE      8'h92
`define FLR_SRC_BYTE       8'h04
`define FLR_TIME_LO        8'h05
`define FLR_TIME_HI        8'h0A
`define FLR_FLUSH_STEP     5'h19
`define FLR_SRC_MANUAL     8'hFF
`define FLR_CH1_OFS        8'h10
`define FLR_LOG_BIT        3
`define FLR_CLR_TIME_NS    8000000
`define FLR_CLK_NS         50
`define FLR_HOT_SET_C      8'h82
`define FLR_HOT_CLR_C      8'h7D
`endif

/* rtl/flr_fault_log.v */
// Purpose: fault log capture, store, readout and erase
// Assumes: telemetry and commands synchronous to clk_sys_in
// Notes:   nonvolatile store is modelled by an internal byte array
// Operation
// - Newest snapshot sits at block bytes 27 to 46, words high byte first.
// - The snapshot one step before the newest (step 24 of the flush) sits at bytes 47 to 66.
// - A snapshot holds vout0/1, iout0/1, vin, iin, status_vout x2, status_word x2, mfr status x2.
// - After a fault, sampling continues to step 25, then header and 6 pages are stored ending at byte 146.
// - Fault source byte is 0xFF for manual store, else the fault code plus 0x10 for channel 1.
// - The erase command wipes the stored log.
// - The erase command clears bit 3 of the mfr status byte (log present).
// - The flag clear completes within 8 ms of the erase command.
// - A log read returns block length 147 when a log exists.
// - With no log captured the block length is zero.
// - The header holds the 48-bit uptime stamp at fault, LSB first in bytes 5 to 10.
// - Manual store is ignored above 130 C until temperature falls below 125 C.
`timescale 1ns/10ps
`include "flr_regs.vh"
module flr_fault_log #(
    parameter CLR_CYCLES = `FLR_CLR_TIME_NS / `FLR_CLK_NS
) (
    input  wire         clk_sys_in,
    input  wire         rstn_in,
    input  wire         sample_in,
    input  wire [4:0]   adc_step_in,
    input  wire [159:0] snap_in,
    input  wire         fault_in,
    input  wire [3:0]   fault_code_in,
    input  wire         fault_ch1_in,
    input  wire         manual_log_save_cmd_in,
    input  wire         log_erase_cmd_in,
    input  wire [47:0]  uptime_stamp_in,
    input  wire [7:0]   die_temp_in,
    input  wire         log_block_read_cmd_in,
    input  wire         rd_next_in,
    output reg  [7:0]   rd_byte_out,
    output reg          log_present_out,
    output reg          busy_out
);
    localparam ST_IDLE  = 2'b00;
    localparam ST_WAIT  = 2'b01;
    localparam ST_STORE = 2'b10;
    localparam ST_ERASE = 2'b11;
    localparam NSNAP    = 6;
    localparam SNAP_W   = 160;
    localparam [3:0] RING_N   = NSNAP;
    localparam [3:0] RING_TOP = NSNAP - 1;

    reg [1:0]   rst_sync_r;
    wire        rst_n = rst_sync_r[1];
    reg [1:0]   state_r;
    wire [NSNAP*SNAP_W-1:0] ring_flat;
    reg [2:0]   wr_ptr_r;
    reg [7:0]   nvm_r [0:`FLR_LAST_BYTE];
    reg [7:0]   src_r;
    reg [47:0]  stamp_r;
    reg [7:0]   idx_r;
    reg [22:0]  clr_cnt_r;
    reg         hot_r;
    reg [7:0]   rd_idx_r;
    reg [7:0]   st_byte;
    reg [2:0]   k;
    reg [7:0]   off;
    reg [2:0]   slot;
    integer     i;
    reg [7:0]   kq;
    reg [3:0]   slot_sum;
    wire        hot_now;
    wire        take_manual;
    wire        ring_wr;
    wire        flush_hit;
    genvar      g;

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // Live temperature so a hot die blocks a manual store in the same cycle
    assign hot_now     = (die_temp_in > `FLR_HOT_SET_C) ||
                         (hot_r && !(die_temp_in < `FLR_HOT_CLR_C));
    assign take_manual = manual_log_save_cmd_in && !hot_now;
    // Ring keeps filling while a fault waits for the flush step
    assign ring_wr     = sample_in &&
                         (state_r == ST_IDLE || state_r == ST_WAIT);
    assign flush_hit   = sample_in && (adc_step_in == `FLR_FLUSH_STEP);

    // Hysteresis flop holds the hot state between 125 and 130 C
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n)
            hot_r <= 1'b0;
        else
            hot_r <= hot_now;
    end

    // One row of flops per ring slot, overwritten until the flush step starts the store
    generate
        for (g = 0; g < NSNAP; g = g + 1) begin : ring_slot
            reg [SNAP_W-1:0] row_r;
            always @(posedge clk_sys_in or negedge rst_n) begin
                if (!rst_n)
                    row_r <= {SNAP_W{1'b0}};
                else if (ring_wr && wr_ptr_r == g)
                    row_r <= snap_in;
            end
            assign ring_flat[g * SNAP_W +: SNAP_W] = row_r;
        end
    endgenerate

    // Header and snapshot byte for the store walk
    always @* begin
        k = 3'd0;
        off = 8'h00;
        slot = 3'd0;
        kq = 8'h00;
        slot_sum = 4'h0;
        st_byte = 8'h00;
        if (idx_r == `FLR_SRC_BYTE) begin
            st_byte = src_r;
        end else if (idx_r >= `FLR_TIME_LO && idx_r <= `FLR_TIME_HI) begin
            st_byte = stamp_r[(idx_r - `FLR_TIME_LO) * 8 +: 8];
        end else if (idx_r >= `FLR_SNAP_BASE) begin
            kq  = (idx_r - `FLR_SNAP_BASE) / `FLR_SNAP_BYTES;
            k   = kq[2:0];
            off = (idx_r - `FLR_SNAP_BASE) - k * `FLR_SNAP_BYTES;
            // Newest is just behind the pointer; four bits stop a wrap
            slot_sum = {1'b0, wr_ptr_r} + RING_TOP - {1'b0, k};
            if (slot_sum >= RING_N)
                slot_sum = slot_sum - RING_N;
            slot = slot_sum[2:0];
            // Field order packed msb first in snap_in
            st_byte = ring_flat[slot * SNAP_W + (SNAP_W - 1) - off * 8 -: 8];
        end
    end

    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wr_ptr_r <= 3'd0;
            src_r <= 8'h00;
            stamp_r <= 48'h0;
            idx_r <= 8'h00;
            clr_cnt_r <= 23'h0;
            log_present_out <= 1'b0;
            busy_out <= 1'b0;
            // Image starts blank so unwritten header bytes read as zero
            for (i = 0; i <= `FLR_LAST_BYTE; i = i + 1)
                nvm_r[i] <= 8'h00;
        end else begin
            // Ring pointer advances with every accepted sample
            if (ring_wr) begin
                wr_ptr_r <= (wr_ptr_r == RING_TOP[2:0]) ? 3'd0
                            : wr_ptr_r + 3'd1;
            end
            case (state_r)
            ST_IDLE: begin
                // Erase takes priority over a capture in the same cycle
                if (log_erase_cmd_in) begin
                    state_r <= ST_ERASE;
                    clr_cnt_r <= 23'h0;
                    busy_out <= 1'b1;
                end else if (fault_in) begin
                    src_r <= {3'b000, fault_ch1_in, fault_code_in};
                    stamp_r <= uptime_stamp_in;
                    state_r <= ST_WAIT;
                    busy_out <= 1'b1;
                end else if (take_manual) begin
                    src_r <= `FLR_SRC_MANUAL;
                    stamp_r <= uptime_stamp_in;
                    state_r <= ST_WAIT;
                    busy_out <= 1'b1;
                end
            end
            ST_WAIT: begin
                if (flush_hit) begin
                    state_r <= ST_STORE;
                    idx_r <= `FLR_SRC_BYTE;
                end
            end
            ST_STORE: begin
                nvm_r[idx_r] <= st_byte;
                if (idx_r == `FLR_LAST_BYTE) begin
                    state_r <= ST_IDLE;
                    log_present_out <= 1'b1;
                    busy_out <= 1'b0;
                end else begin
                    idx_r <= idx_r + 8'h01;
                end
            end
            default: begin
                // Wipe one byte per cycle, flag drops well inside 8 ms
                if (clr_cnt_r <= {15'h0, `FLR_LAST_BYTE})
                    nvm_r[clr_cnt_r[7:0]] <= 8'h00;
                log_present_out <= 1'b0;
                clr_cnt_r <= clr_cnt_r + 23'h1;
                if (clr_cnt_r == CLR_CYCLES[22:0] - 23'h1 ||
                    clr_cnt_r == {15'h0, `FLR_LAST_BYTE}) begin
                    state_r <= ST_IDLE;
                    busy_out <= 1'b0;
                end
            end
            endcase
        end
    end

    // Readout: byte 0 of the stream is the block length
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_idx_r <= 8'h00;
            rd_byte_out <= 8'h00;
        end else if (log_block_read_cmd_in) begin
            rd_idx_r <= 8'h00;
            rd_byte_out <= log_present_out ? `FLR_BLOCK_LEN : 8'h00;
        end else if (rd_next_in) begin
            rd_byte_out <= (log_present_out && rd_idx_r <= `FLR_LAST_BYTE)
                           ? nvm_r[rd_idx_r] : 8'h00;
            rd_idx_r <= (rd_idx_r == 8'hFF) ? rd_idx_r : rd_idx_r + 8'h01;
        end
    end
endmodule

/* bench/flr_fault_log_monitor.sv */
// Purpose: port checks for the fault log recorder
// Assumes: one clock, async active-low reset
// Notes:   bound into every flr_fault_log instance
`timescale 1ns/10ps
module flr_fault_log_monitor (
    input wire       clk_sys_in,
    input wire       rstn_in,
    input wire       sample_in,
    input wire [4:0] adc_step_in,
    input wire       fault_in,
    input wire       manual_log_save_cmd_in,
    input wire       log_erase_cmd_in,
    input wire [7:0] die_temp_in,
    input wire       log_block_read_cmd_in,
    input wire [7:0] rd_byte_out,
    input wire       log_present_out,
    input wire       busy_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire idle = !busy_out && !log_erase_cmd_in && !fault_in;
    len_full_a: assert property (log_block_read_cmd_in && log_present_out
        && !busy_out |=> rd_byte_out == 8'h93) else $error("bad length");
    len_empty_a: assert property (log_block_read_cmd_in && !log_present_out
        && !busy_out |=> rd_byte_out == 8'h00) else $error("not empty");
    fault_take_a: assert property (fault_in && !busy_out |=> busy_out)
        else $error("fault not taken");
    store_end_a: assert property (sample_in && adc_step_in == 5'h19
        && busy_out |-> ##[142:144] log_present_out && !busy_out)
        else $error("store late");
    erase_done_a: assert property (log_erase_cmd_in && !busy_out
        |=> busy_out ##[1:200] !busy_out && !log_present_out)
        else $error("erase late");
    flag_rise_a: assert property ($rose(log_present_out)
        |-> $fell(busy_out)) else $error("flag early");
    hot_skip_a: assert property (manual_log_save_cmd_in && idle
        && die_temp_in > 8'h82 |=> !busy_out) else $error("hot store");
    cool_take_a: assert property (manual_log_save_cmd_in && idle
        && die_temp_in < 8'h7D |=> busy_out) else $error("store lost");
endmodule
bind flr_fault_log flr_fault_log_monitor flr_fault_log_monitor_inst (
    .clk_sys_in, .rstn_in, .sample_in, .adc_step_in, .fault_in,
    .manual_log_save_cmd_in, .log_erase_cmd_in, .die_temp_in,
    .log_block_read_cmd_in, .rd_byte_out, .log_present_out, .busy_out);

/* bench/flr_host_model.sv */
// Purpose: host reading and erasing the log
// Assumes: one command pulse per call
// Notes:   idle cycle between pulses keeps them distinct
`timescale 1ns/10ps
module flr_host_model (
    input  wire clk_sys_in,
    output reg  rd_cmd_out,
    output reg  rd_next_out,
    output reg  erase_out
);
    initial {rd_cmd_out, rd_next_out, erase_out} = 3'h0;
    task pulse(input logic [2:0] w);
        @(posedge clk_sys_in) #1;
        {rd_cmd_out, rd_next_out, erase_out} = w;
        @(posedge clk_sys_in) #1;
        {rd_cmd_out, rd_next_out, erase_out} = 3'h0;
    endtask
endmodule

/* bench/flr_fault_log_tb_top.sv */
// Purpose: self-checking bench for the fault log recorder
// Assumes: 20 MHz clock, reset held 6 cycles
// Notes:   read bytes are checked through a queue
`timescale 1ns/10ps
module flr_fault_log_tb_top;
    reg         clk_sys_in, rstn_in, sample_in, fault_in, fault_ch1_in;
    reg         man_in, rd_v;
    reg [4:0]   adc_step_in;
    reg [3:0]   fault_code_in;
    reg [7:0]   die_temp_in;
    reg [47:0]  stamp;
    reg [159:0] snap_in;
    wire        rd_cmd, rd_nx, ers, pres, busy;
    wire [7:0]  rd_byte;
    logic [7:0] q[$];
    logic [159:0] hist[$];
    logic [7:0] codes[8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                             8'h05, 8'h06, 8'h07, 8'h0A};
    int         errors, total_checks, cyc;
    flr_fault_log #(.CLR_CYCLES(400)) flr_fault_log_inst (
        .clk_sys_in, .rstn_in, .sample_in, .adc_step_in, .snap_in,
        .fault_in, .fault_code_in, .fault_ch1_in,
        .manual_log_save_cmd_in(man_in), .log_erase_cmd_in(ers),
        .uptime_stamp_in(stamp), .die_temp_in,
        .log_block_read_cmd_in(rd_cmd), .rd_next_in(rd_nx),
        .rd_byte_out(rd_byte), .log_present_out(pres), .busy_out(busy));
    flr_host_model flr_host_model_inst (.clk_sys_in, .rd_cmd_out(rd_cmd),
        .rd_next_out(rd_nx), .erase_out(ers));
    initial begin
        clk_sys_in = 1'h0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task results;
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic a, input logic b);
        total_checks++;
        if (a !== b) begin
            errors++;
            $display("[FAIL] %0t flag wrong", $time);
        end
    endtask
    always @(posedge clk_sys_in) begin
        rd_v <= rd_cmd | rd_nx;
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results;
        end
    end
    always @(negedge clk_sys_in) begin
        if (rd_v) begin
            total_checks++;
            if (rd_byte !== q.pop_front()) begin
                errors++;
                $display("[FAIL] %0t byte wrong", $time);
            end
        end
    end
    // Samples run to step 25; the trigger lands after step 15
    task cap(input logic [7:0] src);
        int i;
        stamp = {16'($urandom), $urandom};
        for (i = 0; i < 26; i++) begin
            @(posedge clk_sys_in) #1;
            {sample_in, adc_step_in} = {1'h1, 5'(i)};
            snap_in = {$urandom, $urandom, $urandom, $urandom, $urandom};
            hist.push_front(snap_in);
            @(posedge clk_sys_in) #1;
            sample_in = 1'h0;
            fault_in = (i == 15) && (src != 8'hFF);
            man_in = (i == 15) && (src == 8'hFF);
            {fault_ch1_in, fault_code_in} = src[4:0];
        end
        repeat (300) if (busy) @(posedge clk_sys_in);
    endtask
    task rdlog(input logic [7:0] src, input logic full);
        int b;
        logic [7:0] e;
        flr_host_model_inst.pulse(3'h4);
        q.push_back(full ? 8'h93 : 8'h00);
        for (b = 0; full && b < 147; b++) begin
            e = (b == 4) ? src : 8'h00;
            if (b > 4 && b < 11) e = stamp[8*(b-5) +: 8];
            if (b > 26) e = hist[(b-27)/20][159-8*((b-27)%20) -: 8];
            q.push_back(e);
            flr_host_model_inst.pulse(3'h2);
        end
    endtask
    initial begin
        int i;
        logic [7:0] src;
        {rstn_in, sample_in, fault_in, man_in} = 4'h0;
        {adc_step_in, fault_code_in, fault_ch1_in, snap_in} = 170'h0;
        {stamp, die_temp_in, errors, total_checks} = 120'h0;
        i = $urandom(26);
        repeat (6) @(posedge clk_sys_in);
        #1 rstn_in = 1'h1;
        repeat (3) @(posedge clk_sys_in);
        rdlog(8'h00, 1'h0);
        for (i = 0; i < 8; i++) begin
            src = codes[i] | ($urandom_range(1) ? 8'h10 : 8'h00);
            cap(src);
            rdlog(src, 1'h1);
            flr_host_model_inst.pulse(3'h1);
            repeat (410) @(posedge clk_sys_in);
            chk(pres, 1'h0);
            rdlog(src, 1'h0);
        end
        die_temp_in = 8'h83;
        cap(8'hFF);
        chk(pres, 1'h0);
        die_temp_in = 8'h7C;
        cap(8'hFF);
        rdlog(8'hFF, 1'h1);
        results;
    end
endmodule
